// ---- loop_instrument.sv ----
// loop interface engine of the instrument: forward, address, talk, listen
`timescale 1ns/100ps
module loop_instrument
    import loop_pkg::*;
#(
    parameter int         DEPTH  = FIFO_DEPTH,
    parameter logic [7:0] ACC_ID = 8'h00    // arbitrary accessory code
) (
    // clock and control
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         ce,
    // upstream receiver side
    input  wire logic         rx_valid,
    output logic              rx_ready,
    input  wire frame_t       rx_frame,
    // downstream driver side
    output logic              tx_valid,
    input  wire logic         tx_ready,
    output frame_t            tx_frame,
    // talker source from instrument
    input  wire logic         talk_valid,
    input  wire logic [7:0]   talk_data,
    input  wire logic         talk_last,
    output logic              talk_ack,
    output src_t              talk_src,
    // status and service request
    input  wire logic [7:0]   status_in,
    input  wire logic         srq_req,
    // listener data to instrument
    output logic              listen_valid,
    output logic [7:0]        listen_data,
    // device state and events
    output role_t             role,
    output logic [4:0]        addr,
    output logic              addr_ok,
    output logic              clear,
    output logic              trigger,
    output logic              power_down,
    output logic              err
);

    // buffered upstream frames
    frame_t   f_frame;              // head of the receive buffer
    logic     f_valid;              // buffer holds a frame
    logic     f_pop;                // engine takes the head frame

    // registered state
    state_t   state_q;              // loop engine state
    src_t     src_q;                // current talker source
    role_t    role_q;               // addressed role
    frame_t   tx_frame_q;           // frame on the driver, kept for compare
    logic     tx_valid_q;           // driver offer
    logic     last_q;               // last stream word sent
    logic [4:0] addr_q;             // assigned loop address
    logic     addr_ok_q;            // an address has been assigned
    logic     talk_ack_q;           // talker word taken
    logic     err_q;                // returned frame differed
    logic     clear_q;              // clear event
    logic     trigger_q;            // trigger event
    logic     pd_q;                 // powered down
    logic     lsn_valid_q;          // listener word ready
    logic [7:0] lsn_data_q;         // listener word

    frame_fifo #(
        .WIDTH (FRAME_W),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .clock     (clock),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_frame),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_frame)
    );

    wire        is_cmd  = (f_frame.cls == CLS_CMD);
    wire        is_rdy  = (f_frame.cls == CLS_RDY);
    wire        is_data = (f_frame.cls[2:1] == CLS_DATA[2:1]);
    wire [4:0]  f_addr  = f_frame.msg[4:0];
    wire [2:0]  f_grp   = f_frame.msg[7:5];
    wire        mine    = addr_ok_q && (f_addr == addr_q);
    wire        talker  = (role_q == ROLE_TALK);
    wire        lsnr    = (role_q == ROLE_LISTEN);

    // addressing commands
    wire lad = is_cmd && (f_grp == GRP_LAD) && (f_addr != ADDR_ALL);
    wire tad = is_cmd && (f_grp == GRP_TAD) && (f_addr != ADDR_ALL);
    wire unl = is_cmd && (f_frame.msg == MSG_UNL);
    wire unt = is_cmd && (f_frame.msg == MSG_UNT);
    wire ifc = is_cmd && (f_frame.msg == MSG_IFC);
    // universal and selected clear, trigger, power down
    wire dcl = is_cmd && (f_frame.msg == MSG_DCL);
    wire sdc = is_cmd && (f_frame.msg == MSG_SDC);
    wire get = is_cmd && (f_frame.msg == MSG_GET);
    wire lpd = is_cmd && (f_frame.msg == MSG_LPD);
    // auto address, the all-ones code is passed on untouched
    wire aad = is_rdy && (f_grp == GRP_AAD) && (f_addr != ADDR_ALL);
    // talker prompts
    wire sda = is_rdy && (f_frame.msg == MSG_SDA);
    wire sst = is_rdy && (f_frame.msg == MSG_SST);
    wire sdi = is_rdy && (f_frame.msg == MSG_SDI);
    wire sai = is_rdy && (f_frame.msg == MSG_SAI);

    // sending starts only from a prompt while talker
    wire start_src = talker && (sda || sst || sdi || sai);
    wire take      = f_pop && (state_q == ST_IDLE);
    wire ret       = f_pop && (state_q == ST_WAIT);

    // the buffer is read only when nothing of ours is on the driver
    assign f_pop = ce && f_valid
                   && ((state_q == ST_IDLE) || (state_q == ST_WAIT));

    // forwarded frame: next address up, srq flag on passing data
    wire [7:0] fwd_msg = aad ? f_frame.msg + 8'h01 : f_frame.msg;
    wire [2:0] fwd_cls = (is_data && srq_req) ? (f_frame.cls | CLS_SRQ)
                                              : f_frame.cls;
    // everything else goes on bit for bit
    wire frame_t fwd_frame = '{cls: fwd_cls, msg: fwd_msg};

    // status byte carries the request bit
    wire frame_t status_frame = '{cls: CLS_DATA,
        msg: {status_in[7], srq_req, status_in[5:0]}};
    wire frame_t acc_frame    = '{cls: CLS_DATA, msg: ACC_ID};
    wire frame_t talk_frame   = '{cls: CLS_DATA, msg: talk_data};
    wire single = (src_q == SRC_STATUS) || (src_q == SRC_ACC);

    // loop engine: forward, send own frame, wait for its return
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            src_q      <= SRC_DATA;
            tx_frame_q <= '0;
            tx_valid_q <= 1'b0;
            last_q     <= 1'b0;
            talk_ack_q <= 1'b0;
            err_q      <= 1'b0;
        end else if (ce) begin
            talk_ack_q <= 1'b0;
            err_q      <= 1'b0;
            case (state_q)
                // take a frame from upstream
                ST_IDLE: begin
                    if (take && start_src) begin
                        // status, ids or data on request
                        src_q  <= sst ? SRC_STATUS : sai ? SRC_ACC :
                                  sdi ? SRC_DEVID : SRC_DATA;
                        last_q <= 1'b0;
                        if (sst || sai) begin
                            tx_frame_q <= sst ? status_frame : acc_frame;
                            tx_valid_q <= 1'b1;
                            state_q    <= ST_SEND;
                        end else begin
                            state_q <= ST_FETCH;
                        end
                    end else if (take) begin
                        tx_frame_q <= fwd_frame;
                        tx_valid_q <= 1'b1;
                        state_q    <= ST_FWD;
                    end
                end
                // forwarded frame waits for downstream acceptance
                ST_FWD: begin
                    if (tx_ready) begin
                        tx_valid_q <= 1'b0;
                        state_q    <= ST_IDLE;
                    end
                end
                // own frame waits for downstream acceptance
                ST_SEND: begin
                    if (tx_ready) begin
                        tx_valid_q <= 1'b0;
                        state_q    <= ST_WAIT;
                    end
                end
                // returned frame must match what was sent
                ST_WAIT: begin
                    if (ret) begin
                        err_q <= (f_frame != tx_frame_q);
                        if (tx_frame_q == EOT_FRAME) begin
                            state_q <= ST_IDLE;
                        end else if (single || last_q) begin
                            tx_frame_q <= EOT_FRAME;
                            tx_valid_q <= 1'b1;
                            state_q    <= ST_SEND;
                        end else begin
                            state_q <= ST_FETCH;
                        end
                    end
                end
                // next word from the instrument's talker stream
                ST_FETCH: begin
                    if (talk_valid) begin
                        tx_frame_q <= talk_frame;
                        tx_valid_q <= 1'b1;
                        last_q     <= talk_last;
                        talk_ack_q <= 1'b1;
                        state_q    <= ST_SEND;
                    end
                end
                default: begin
                    tx_valid_q <= 1'b0;
                    state_q    <= ST_IDLE;
                end
            endcase
        end
    end

    // role changes only on addressing and interface clear
    always_ff @(posedge clock) begin
        if (rst) begin
            role_q <= ROLE_NONE;
        end else if (ce && take) begin
            if (ifc) begin
                role_q <= ROLE_NONE;
            end else if (lad && mine) begin
                role_q <= ROLE_LISTEN;
            end else if (tad && mine) begin
                role_q <= ROLE_TALK;
            end else if ((unl && lsnr) || ((unt || tad) && talker)) begin
                role_q <= ROLE_NONE;
            end
        end
    end

    // single address from the auto-address frame
    always_ff @(posedge clock) begin
        if (rst) begin
            addr_q    <= ADDR_RST;
            addr_ok_q <= 1'b0;
        end else if (ce && take && aad) begin
            addr_q    <= f_addr;
            addr_ok_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            clear_q     <= 1'b0;
            trigger_q   <= 1'b0;
            pd_q        <= 1'b0;
            lsn_valid_q <= 1'b0;
            lsn_data_q  <= 8'h00;
        end else if (ce) begin
            clear_q     <= take && (dcl || (sdc && lsnr));
            trigger_q   <= take && get && lsnr;
            pd_q        <= take ? lpd : pd_q;
            lsn_valid_q <= take && is_data && lsnr;
            lsn_data_q  <= take ? f_frame.msg : lsn_data_q;
        end
    end

    // no controller, manual request or device commands
    assign tx_valid     = tx_valid_q;
    assign tx_frame     = tx_frame_q;
    assign talk_ack     = talk_ack_q;
    assign talk_src     = src_q;
    assign listen_valid = lsn_valid_q;
    assign listen_data  = lsn_data_q;
    assign role         = role_q;
    assign addr         = addr_q;
    assign addr_ok      = addr_ok_q;
    assign clear        = clear_q;
    assign trigger      = trigger_q;
    assign power_down   = pd_q;
    assign err          = err_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_class_legal;
        tx_valid |-> (tx_frame.cls == CLS_DATA || tx_frame.cls == CLS_SRQ
                      || tx_frame.cls == CLS_CMD || tx_frame.cls == CLS_RDY);
    endproperty
    a_class_legal: assert property (p_class_legal)
        else $error("illegal frame class driven");

    property p_drv_hold;
        tx_valid && !(ce && tx_ready) |=> tx_valid && $stable(tx_frame);
    endproperty
    a_drv_hold: assert property (p_drv_hold)
        else $error("driver offer dropped or changed");

    property p_one_in_transit;
        state_q == ST_WAIT |-> !tx_valid;
    endproperty
    a_one_in_transit: assert property (p_one_in_transit)
        else $error("second frame offered before return");

    property p_forward;
        take && !start_src && !aad && !is_data |=>
            tx_valid && tx_frame == $past(f_frame);
    endproperty
    a_forward: assert property (p_forward)
        else $error("frame not passed on unchanged");

    property p_mismatch;
        ret && (f_frame != tx_frame_q) |=> err;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("returned mismatch not flagged");

    property p_no_prompt_unaddr;
        take && sda && !talker |=> state_q == ST_FWD ##1 !talk_ack;
    endproperty
    a_no_prompt_unaddr: assert property (p_no_prompt_unaddr)
        else $error("unaddressed device started talking");

    property p_listen_gate;
        listen_valid |-> $past(role_q) == ROLE_LISTEN;
    endproperty
    a_listen_gate: assert property (p_listen_gate)
        else $error("data delivered while not listener");

    property p_lad_drops_talk;
        take && lad && mine && !ifc |=> role == ROLE_LISTEN;
    endproperty
    a_lad_drops_talk: assert property (p_lad_drops_talk)
        else $error("listen address did not set listener");

    property p_tad_drops_listen;
        take && tad && mine && !ifc |=> role == ROLE_TALK;
    endproperty
    a_tad_drops_listen: assert property (p_tad_drops_listen)
        else $error("talk address did not set talker");

    property p_clear;
        take && (dcl || (sdc && lsnr)) |=> clear ##1 !clear || $past(take);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear command without clear pulse");

    property p_trigger;
        take && get && lsnr |=> trigger;
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("trigger command not acted on");

    property p_auto_addr;
        take && aad |=> addr_ok && addr == $past(f_addr)
            && tx_frame.msg == $past(f_frame.msg) + 8'h01;
    endproperty
    a_auto_addr: assert property (p_auto_addr)
        else $error("auto address not taken or not advanced");

    property p_eot_after_status;
        ret && src_q == SRC_STATUS && tx_frame_q != EOT_FRAME
            |=> tx_valid && tx_frame == EOT_FRAME;
    endproperty
    a_eot_after_status: assert property (p_eot_after_status)
        else $error("status byte not closed by end frame");

    c_forward:   cover property (take ##[1:4] (tx_valid && tx_ready));
    c_auto_addr: cover property (take && aad);
    c_talk_done: cover property (ret && tx_frame_q == EOT_FRAME);
    c_listen:    cover property (listen_valid);

endmodule : loop_instrument

// ---- loop_pkg.sv ----
// constants, types and frame layout for the serial loop instrument interface
//
// Contract
// - every message is one eleven-bit frame
// - three class bits, eight message bits
// - originator compares returned frame, flags mismatch
// - one own frame in transit at once
// - frames not for us retransmitted unchanged
// - handshake as receiver and as driver
// - talk only after addressed, no talk-only
// - ignore data until addressed to listen
// - take auto-address, no extended or multiple
// - never act as loop controller
// - talker sends status, ids; unaddressed by listen
// - listener unaddressed when addressed to talk
// - universal and selected clear restore state
// - trigger command starts triggered action
// - remote, local, lockout are no-ops
// - basic and asynchronous service request; only basic here: srq flag on passing data and in the status byte
// - no parallel poll response
// - no manual service request, no device commands
// - power-down mode commanded over loop
package loop_pkg;

    // frame geometry
    localparam int FRAME_W    = 11;
    localparam int CLS_W      = 3;
    localparam int MSG_W      = 8;
    localparam int ADDR_W     = 5;
    localparam int FIFO_DEPTH = 8;

    // frame classes
    localparam logic [2:0] CLS_DATA = 3'h0;
    localparam logic [2:0] CLS_SRQ  = 3'h1;  // service request bit
    localparam logic [2:0] CLS_CMD  = 3'h4;
    localparam logic [2:0] CLS_RDY  = 3'h5;

    // command class messages
    localparam logic [2:0] GRP_LAD  = 3'h1;  // msg[7:5] of listen addr
    localparam logic [2:0] GRP_TAD  = 3'h2;  // msg[7:5] of talk addr
    localparam logic [4:0] ADDR_ALL = 5'h1f; // un-address code
    localparam logic [7:0] MSG_UNL  = 8'h3f;
    localparam logic [7:0] MSG_UNT  = 8'h5f;
    localparam logic [7:0] MSG_DCL  = 8'h14;
    localparam logic [7:0] MSG_SDC  = 8'h04;
    localparam logic [7:0] MSG_GET  = 8'h08;
    localparam logic [7:0] MSG_IFC  = 8'h90;
    localparam logic [7:0] MSG_LPD  = 8'h9b;

    // ready class messages
    localparam logic [2:0] GRP_AAD  = 3'h4;  // msg[7:5] of auto address
    localparam logic [7:0] MSG_EOT  = 8'h40;
    localparam logic [7:0] MSG_SDA  = 8'h60;
    localparam logic [7:0] MSG_SST  = 8'h61;
    localparam logic [7:0] MSG_SDI  = 8'h62;
    localparam logic [7:0] MSG_SAI  = 8'h63;

    // reset values
    localparam logic [4:0] ADDR_RST = 5'h00;

    // one loop frame
    typedef struct packed {
        logic [2:0] cls;
        logic [7:0] msg;
    } frame_t;

    localparam frame_t EOT_FRAME = '{cls: CLS_RDY, msg: MSG_EOT};

    // addressed role of the device
    typedef enum logic [1:0] {
        ROLE_NONE   = 2'b00,
        ROLE_TALK   = 2'b01,
        ROLE_LISTEN = 2'b10
    } role_t;

    // what the talker is sending
    typedef enum logic [1:0] {
        SRC_DATA   = 2'b00,
        SRC_DEVID  = 2'b01,
        SRC_STATUS = 2'b10,
        SRC_ACC    = 2'b11
    } src_t;

    // loop engine states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FWD   = 3'b001,
        ST_SEND  = 3'b010,
        ST_WAIT  = 3'b011,
        ST_FETCH = 3'b100
    } state_t;

endpackage : loop_pkg

// ---- frame_fifo.sv ----
// receive buffer between the upstream link and the loop engine
`timescale 1ns/100ps
module frame_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    // clock and control
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             ce,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];      // storage array
    logic [AW-1:0]    wr_ptr_q;         // next write slot
    logic [AW-1:0]    rd_ptr_q;         // next read slot
    logic [AW:0]      count_q;          // words held
    logic [AW:0]      count_d;
    logic             in_ready_q;       // registered not-full

    // transfers on each side
    wire push = ce && in_valid && in_ready_q;
    wire pop  = ce && out_valid && out_ready;
    wire [AW-1:0] wr_next = (wr_ptr_q == AW'(DEPTH - 1)) ? '0
                                                         : wr_ptr_q + 1'b1;
    wire [AW-1:0] rd_next = (rd_ptr_q == AW'(DEPTH - 1)) ? '0
                                                         : rd_ptr_q + 1'b1;

    assign count_d   = count_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (count_q != '0);
    assign out_data  = mem[rd_ptr_q];
    assign in_ready  = in_ready_q;

    // data store, no reset needed
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            count_q    <= '0;
            in_ready_q <= 1'b0;
        end else if (ce) begin
            wr_ptr_q   <= push ? wr_next : wr_ptr_q;
            rd_ptr_q   <= pop ? rd_next : rd_ptr_q;
            count_q    <= count_d;
            in_ready_q <= (count_d != (AW+1)'(DEPTH));
        end
    end

endmodule : frame_fifo

// ---- loop_ctrl_model.sv ----
// behavioural loop controller standing for the rest of the loop
`timescale 1ns/100ps
module loop_ctrl_model
    import loop_pkg::*;
(
    // clock
    input  wire logic   clock,
    // frames toward the device
    output logic        rx_valid,
    input  wire logic   rx_ready,
    output frame_t      rx_frame,
    // frames from the device
    input  wire logic   tx_valid,
    output logic        tx_ready,
    input  wire frame_t tx_frame,
    // stall the return side
    input  wire logic   slow
);
    frame_t send_q[$];  // frames queued for sending
    frame_t got_q[$];   // frames received back
    initial begin
        rx_valid = 1'b0;
        rx_frame = '0;
        tx_ready = 1'b0;
    end
    // single frame offered, held until taken
    always begin
        @(posedge clock);
        if (send_q.size() != 0) begin
            #1 rx_frame = send_q.pop_front();
            rx_valid = 1'b1;
            do @(posedge clock); while (rx_ready !== 1'b1);
            #1 rx_valid = 1'b0;
            // released line must not keep the last frame
            rx_frame = ~rx_frame;
        end
    end
    // accept frames, stalling every other cycle when slow
    always @(posedge clock) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) got_q.push_back(tx_frame);
        #1 tx_ready = slow ? ~tx_ready : 1'b1;
    end
endmodule : loop_ctrl_model

// ---- tb.sv ----
// self-checking bench for the loop instrument engine
`timescale 1ns/100ps
module tb
    import loop_pkg::*;
;
    logic       clock, rst, ce, slow, rx_valid, rx_ready, tx_valid;
    logic       tx_ready, talk_valid, talk_last, talk_ack, srq_req;
    logic       listen_valid, addr_ok, clear, trigger, power_down, err;
    frame_t     rx_frame, tx_frame;
    logic [7:0] talk_data, status_in, listen_data, last_lis;
    src_t       talk_src;
    role_t      role;
    logic [4:0] addr;
    int         n_errors, n_checks, cyc, n_clr, n_trg, n_lis, n_err, n_ack;

    loop_instrument u_loop_instrument (
        .clock, .rst, .ce, .rx_valid, .rx_ready, .rx_frame, .tx_valid,
        .tx_ready, .tx_frame, .talk_valid, .talk_data, .talk_last,
        .talk_ack, .talk_src, .status_in, .srq_req, .listen_valid,
        .listen_data, .role, .addr, .addr_ok, .clear, .trigger,
        .power_down, .err
    );
    loop_ctrl_model u_loop_ctrl_model (
        .clock, .rx_valid, .rx_ready, .rx_frame, .tx_valid, .tx_ready,
        .tx_frame, .slow
    );
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // count event pulses and cut a hang short
    always @(posedge clock) begin
        cyc++;
        n_clr += (clear === 1'b1);
        n_trg += (trigger === 1'b1);
        n_lis += (listen_valid === 1'b1);
        n_err += (err === 1'b1);
        n_ack += (talk_ack === 1'b1);
        if (listen_valid === 1'b1) last_lis = listen_data;
        if (cyc == 4000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk_f(input frame_t g, input frame_t e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t frame got %h exp %h", $time, g, e);
        end
    endtask : chk_f
    task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t value got %h exp %h", $time, g, e);
        end
    endtask : chk_v
    task automatic put(input frame_t f);
        u_loop_ctrl_model.send_q.push_back(f);
    endtask : put
    task automatic get_tx(output frame_t f);
        int k;
        k = 0;
        while (u_loop_ctrl_model.got_q.size() == 0 && k < 100) begin
            @(posedge clock);
            k++;
        end
        f = 'x;
        if (k < 100) f = u_loop_ctrl_model.got_q.pop_front();
    endtask : get_tx
    task automatic send(input frame_t f, input frame_t e);
        frame_t g;
        put(f);
        get_tx(g);
        chk_f(g, e);
        @(posedge clock);
    endtask : send
    task automatic t_addr;
        chk_v({6'h0, role}, 8'h00);
        send({CLS_RDY, 8'h81}, {CLS_RDY, 8'h82});
        chk_v({3'h0, addr}, 8'h01);
        chk_v({7'h0, addr_ok}, 8'h01);
        $display("test addressing done");
    endtask : t_addr
    task automatic t_fwd;
        frame_t fl [5] = '{{CLS_CMD, 8'h01}, {CLS_CMD, 8'h11},
            {CLS_CMD, 8'h22}, {CLS_RDY, MSG_SST}, {CLS_DATA, 8'h55}};
        foreach (fl[i]) send(fl[i], fl[i]);
        chk_v({6'h0, role}, 8'h00);
        chk_v(8'(n_lis + n_ack), 8'h00);
        $display("test forwarding done");
    endtask : t_fwd
    task automatic t_listen;
        send({CLS_CMD, 8'h21}, {CLS_CMD, 8'h21});
        chk_v({6'h0, role}, {6'h0, ROLE_LISTEN});
        send({CLS_DATA, 8'ha5}, {CLS_DATA, 8'ha5});
        chk_v(last_lis, 8'ha5);
        send({CLS_CMD, MSG_SDC}, {CLS_CMD, MSG_SDC});
        send({CLS_CMD, MSG_DCL}, {CLS_CMD, MSG_DCL});
        send({CLS_CMD, MSG_GET}, {CLS_CMD, MSG_GET});
        chk_v(8'(n_trg), 8'h01);
        send({CLS_CMD, 8'h41}, {CLS_CMD, 8'h41});
        chk_v({6'h0, role}, {6'h0, ROLE_TALK});
        send({CLS_CMD, MSG_SDC}, {CLS_CMD, MSG_SDC});
        chk_v(8'(n_clr), 8'h02);
        $display("test listener done");
    endtask : t_listen
    task automatic t_stat;
        frame_t g;
        put({CLS_RDY, MSG_SST});
        get_tx(g);
        chk_f(g, {CLS_DATA, 8'h05});
        put({CLS_DATA, 8'h07});
        get_tx(g);
        chk_f(g, EOT_FRAME);
        put(g);
        repeat (4) @(posedge clock);
        chk_v(8'(n_err), 8'h01);
        $display("test status done");
    endtask : t_stat
    task automatic t_data;
        frame_t g;
        #1 slow = 1'b1;
        talk_valid = 1'b1;
        put({CLS_RDY, MSG_SDA});
        get_tx(g);
        chk_f(g, {CLS_DATA, 8'h3c});
        chk_v({6'h0, talk_src}, {6'h0, SRC_DATA});
        #1 talk_data = 8'hc3;
        talk_last = 1'b1;
        repeat (10) @(posedge clock);
        chk_v(8'(u_loop_ctrl_model.got_q.size()), 8'h00);
        put(g);
        get_tx(g);
        chk_f(g, {CLS_DATA, 8'hc3});
        #1 talk_valid = 1'b0;
        put(g);
        get_tx(g);
        chk_f(g, EOT_FRAME);
        put(g);
        repeat (6) @(posedge clock);
        chk_v(8'(n_ack), 8'h02);
        #1 slow = 1'b0;
        $display("test talker data done");
    endtask : t_data
    task automatic t_end;
        send({CLS_CMD, 8'h21}, {CLS_CMD, 8'h21});
        chk_v({6'h0, role}, {6'h0, ROLE_LISTEN});
        #1 srq_req = 1'b1;
        send({CLS_DATA, 8'h11}, {CLS_SRQ, 8'h11});
        send({CLS_CMD, MSG_LPD}, {CLS_CMD, MSG_LPD});
        chk_v({7'h0, power_down}, 8'h01);
        send({CLS_CMD, 8'h01}, {CLS_CMD, 8'h01});
        chk_v({7'h0, power_down}, 8'h00);
        $display("test power down done");
    endtask : t_end
    task automatic t_role;
        frame_t g;
        send({CLS_CMD, MSG_UNL}, {CLS_CMD, MSG_UNL});
        chk_v({6'h0, role}, 8'h00);
        send({CLS_CMD, 8'h41}, {CLS_CMD, 8'h41});
        put({CLS_RDY, MSG_SAI});
        get_tx(g);
        chk_f(g, {CLS_DATA, 8'h00});
        chk_v({6'h0, talk_src}, {6'h0, SRC_ACC});
        put(g);
        get_tx(g);
        chk_f(g, EOT_FRAME);
        put(g);
        repeat (4) @(posedge clock);
        send({CLS_CMD, 8'h42}, {CLS_CMD, 8'h42});
        chk_v({6'h0, role}, 8'h00);
        send({CLS_CMD, 8'h21}, {CLS_CMD, 8'h21});
        send({CLS_CMD, MSG_IFC}, {CLS_CMD, MSG_IFC});
        chk_v({6'h0, role}, 8'h00);
        $display("test roles done");
    endtask : t_role
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        {rst, ce, slow, srq_req} = 4'b1100;
        {talk_valid, talk_last, talk_data, status_in} = {2'b00, 16'h3c45};
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        t_addr();
        t_fwd();
        t_listen();
        t_stat();
        t_data();
        t_end();
        t_role();
        tally_and_finish();
    end
endmodule : tb
